// ==== atc_timer.sv ====
// Eight-bit timer/counter with asynchronous clock option and PWM mode.
// What this block does
// - In PWM mode the overflow flag sets when the counter moves on from zero.
// - PWM overflow and compare flags raise interrupts as in normal counting.
// - In PWM mode the output period is the timer clock divided by 510.
// - The counter runs from the source tick, a prescaled tick, or stops.
// - The async select bit moves the timer onto the oscillator pin.
// - An async count write sets count busy until the counter is loaded.
// - An async compare write sets compare busy until compare is loaded.
// - An async control write sets control busy until control is loaded.
// - Count reads are live; compare and control reads give temp storage.
// - Bits 7..4 of the async status register always read zero.
// - Async flag sync takes one timer cycle plus three processor cycles.
// - The compare output changes on the timer tick, not after flag sync.
// - A timer wake-up halts the processor for four cycles.
// - With async select the counter runs in power-save and may wake.
`timescale 1ns/1ps

module atc_timer (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic osc_input_pin_i,
  input wire logic global_irq_en_i,
  input wire logic sleep_power_save_i,
  output logic irq_o,
  output logic pwm_output_pin_o,
  output logic osc_pins_claimed_o,
  output logic wake_o,
  output logic cpu_halt_o
);

  localparam int PW = 2 * `ATC_FLAG_SYNC_CYCLES;

  atc_pkg::atc_top_t r;
  atc_pkg::atc_top_t n;

  logic osc_s;
  logic src_tick;
  logic tick;
  logic match;
  logic [1:0] com;
  logic [1:0] evt;
  logic [1:0] push;
  logic [1:0] set;
  logic [1:0] clr;

  // ----------------------------------------------------------------------
  // Timer source and prescaler
  // ----------------------------------------------------------------------
  atc_sync2 u_osc_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .async_i(osc_input_pin_i),
    .sync_o(osc_s)
  );

  // The oscillator is sampled, so it must run well below half of clk_i.
  // In power-save the system clock tick stops, the oscillator tick does not.
  always_comb begin
    if (r.async_sel) begin
      src_tick = osc_s && !r.osc_d;
    end else begin
      src_tick = !sleep_power_save_i;
    end
  end

  atc_prescale u_prescale (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .src_tick_i(src_tick),
    .sel_i(r.ctrl[`ATC_CTL_CS_HI:`ATC_CTL_CS_LO]),
    .tick_o(tick)
  );

  assign com = r.ctrl[`ATC_CTL_COM_HI:`ATC_CTL_COM_LO];
  assign match = (r.count == r.cmp);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    n = r;
    evt = 2'h0;
    push = 2'h0;
    set = 2'h0;
    clr = 2'h0;
    n.osc_d = osc_s;

    // Counting, one step per timer tick.
    if (tick) begin
      if (r.ctrl[`ATC_CTL_PWM]) begin
        // Up to all ones and back down: 255 + 255 ticks per period.
        if (r.count == 8'h00) begin
          evt[`ATC_FLG_OVF] = 1'b1;
        end
        if (match) begin
          evt[`ATC_FLG_CMP] = 1'b1;
        end
        if (r.dir == atc_pkg::ATC_UP) begin
          if (r.count == 8'hff) begin
            n.dir = atc_pkg::ATC_DOWN;
            n.count = 8'hfe;
          end else begin
            n.count = r.count + 8'h01;
          end
        end else if (r.count <= 8'h01) begin
          n.dir = atc_pkg::ATC_UP;
          n.count = 8'h00;
        end else begin
          n.count = r.count - 8'h01;
        end
        if (com[1]) begin
          if (r.cmp == 8'hff) begin
            n.oc = (com == 2'h2);
          end else if (r.cmp == 8'h00) begin
            n.oc = (com == 2'h3);
          end else if (match) begin
            // Non-inverted clears counting up; inverted sets counting up.
            n.oc = ((r.dir == atc_pkg::ATC_UP) == com[0]);
          end
        end
      end else begin
        if (r.count == 8'hff) begin
          evt[`ATC_FLG_OVF] = 1'b1;
        end
        if (match) begin
          evt[`ATC_FLG_CMP] = 1'b1;
        end
        if (match && r.ctrl[`ATC_CTL_CLR_ON_CMP]) begin
          n.count = 8'h00;
        end else begin
          n.count = r.count + 8'h01;
        end
        if (match) begin
          case (com)
            2'h1: n.oc = !r.oc;
            2'h2: n.oc = 1'b0;
            2'h3: n.oc = 1'b1;
            default: n.oc = r.oc;
          endcase
        end
      end
    end

    // ----------------------------------------------------------------------
    // Async update from temporary storage on the timer clock
    // ----------------------------------------------------------------------
    if (r.async_sel && src_tick) begin
      if (r.busy_cnt) begin
        n.count = r.cnt_tmp;
        n.busy_cnt = 1'b0;
      end
      if (r.busy_cmp) begin
        n.cmp = r.cmp_tmp;
        n.busy_cmp = 1'b0;
      end
      if (r.busy_ctrl) begin
        n.ctrl = r.ctrl_tmp;
        n.busy_ctrl = 1'b0;
      end
    end

    // ----------------------------------------------------------------------
    // Flag synchronisation
    // ----------------------------------------------------------------------
    // An event waits for the next timer tick, then three system cycles.
    if (r.async_sel && src_tick) begin
      push = r.pend;
      n.pend = evt;
    end else begin
      n.pend = r.pend | evt;
    end
    if (!r.async_sel) begin
      n.pend = 2'h0;
      set = evt;
    end
    n.pipe = {r.pipe[PW-3:0], push};
    set = set | r.pipe[PW-1:PW-2];

    // ----------------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------------
    if (wr_i) begin
      if (addr_i == `ATC_ADDR_STATUS) begin
        n.async_sel = wdata_i[`ATC_ST_ASYNC];
        if (wdata_i[`ATC_ST_ASYNC] != r.async_sel) begin
          // Pending transfers are dropped; software rewrites them.
          n.busy_cnt = 1'b0;
          n.busy_cmp = 1'b0;
          n.busy_ctrl = 1'b0;
        end
      end else if (addr_i == `ATC_ADDR_COUNT) begin
        n.cnt_tmp = wdata_i;
        if (r.async_sel) begin
          n.busy_cnt = 1'b1;
        end else begin
          n.count = wdata_i;
        end
      end else if (addr_i == `ATC_ADDR_COMPARE) begin
        n.cmp_tmp = wdata_i;
        if (r.async_sel) begin
          n.busy_cmp = 1'b1;
        end else begin
          n.cmp = wdata_i;
        end
      end else if (addr_i == `ATC_ADDR_CONTROL) begin
        n.ctrl_tmp = wdata_i;
        if (r.async_sel) begin
          n.busy_ctrl = 1'b1;
        end else begin
          n.ctrl = wdata_i;
        end
      end else if (addr_i == `ATC_ADDR_FLAGS) begin
        clr = wdata_i[1:0];
      end else if (addr_i == `ATC_ADDR_MASK) begin
        n.mask = wdata_i[1:0];
      end
    end

    // A flag set by hardware in the same cycle as its clear stays set.
    n.flags = (r.flags & ~clr) | set;

    // ----------------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------------
    n.rdata = 8'h00;
    if (rd_i) begin
      if (addr_i == `ATC_ADDR_STATUS) begin
        n.rdata = {4'h0, r.async_sel, r.busy_cnt, r.busy_cmp,
                   r.busy_ctrl};
      end else if (addr_i == `ATC_ADDR_COUNT) begin
        n.rdata = r.count;
      end else if (addr_i == `ATC_ADDR_COMPARE) begin
        n.rdata = r.cmp_tmp;
      end else if (addr_i == `ATC_ADDR_CONTROL) begin
        n.rdata = r.ctrl_tmp;
      end else if (addr_i == `ATC_ADDR_FLAGS) begin
        n.rdata = {6'h00, r.flags};
      end else if (addr_i == `ATC_ADDR_MASK) begin
        n.rdata = {6'h00, r.mask};
      end
    end

    // ----------------------------------------------------------------------
    // Interrupt, wake-up and halt
    // ----------------------------------------------------------------------
    n.irq = global_irq_en_i && ((n.flags & n.mask) != 2'h0);
    // Wake does not need the global enable, so a sleeping part still wakes.
    n.wake = sleep_power_save_i && r.async_sel &&
             ((n.flags & n.mask) != 2'h0);
    if (n.wake && !r.wake) begin
      n.halt_cnt = `ATC_WAKE_HALT_CYCLES;
    end else if (r.halt_cnt != 3'h0) begin
      n.halt_cnt = r.halt_cnt - 3'h1;
    end
    n.halt = (n.halt_cnt != 3'h0);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign rdata_o = r.rdata;
  assign irq_o = r.irq;
  assign pwm_output_pin_o = r.oc;
  assign osc_pins_claimed_o = r.async_sel;
  assign wake_o = r.wake;
  assign cpu_halt_o = r.halt;

endmodule : atc_timer

// ==== atc_defines.svh ====
// Register offsets, field positions, reset values and timing counts.
`ifndef ATC_DEFINES_SVH
`define ATC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ATC_ADDR_STATUS 8'h22
`define ATC_ADDR_COMPARE 8'h23
`define ATC_ADDR_COUNT 8'h24
`define ATC_ADDR_CONTROL 8'h25
`define ATC_ADDR_FLAGS 8'h38
`define ATC_ADDR_MASK 8'h39

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ATC_ST_ASYNC 3
`define ATC_ST_CNT_BUSY 2
`define ATC_ST_CMP_BUSY 1
`define ATC_ST_CTL_BUSY 0
`define ATC_CTL_CS_HI 2
`define ATC_CTL_CS_LO 0
`define ATC_CTL_CLR_ON_CMP 3
`define ATC_CTL_COM_HI 5
`define ATC_CTL_COM_LO 4
`define ATC_CTL_PWM 6
`define ATC_FLG_OVF 0
`define ATC_FLG_CMP 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ATC_RST_BYTE 8'h00
`define ATC_RST_FLAGS 2'h0

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define ATC_FLAG_SYNC_CYCLES 3
`define ATC_WAKE_HALT_CYCLES 3'h4
`define ATC_PWM_TICKS_PER_PERIOD 510
`define ATC_PRE_MASK_8 10'h007
`define ATC_PRE_MASK_32 10'h01f
`define ATC_PRE_MASK_64 10'h03f
`define ATC_PRE_MASK_128 10'h07f
`define ATC_PRE_MASK_256 10'h0ff
`define ATC_PRE_MASK_1024 10'h3ff

`endif

// ==== atc_pkg.sv ====
// Types shared by the timer/counter modules.
`include "atc_defines.svh"

package atc_pkg;

  typedef enum logic {ATC_UP, ATC_DOWN} atc_dir_t;

  typedef struct packed {
    logic [7:0] count;
    logic [7:0] cmp;
    logic [7:0] ctrl;
    logic [7:0] cnt_tmp;
    logic [7:0] cmp_tmp;
    logic [7:0] ctrl_tmp;
    logic async_sel;
    logic busy_cnt;
    logic busy_cmp;
    logic busy_ctrl;
    logic [1:0] flags;
    logic [1:0] mask;
    logic [1:0] pend;
    logic [2*`ATC_FLAG_SYNC_CYCLES-1:0] pipe;
    atc_dir_t dir;
    logic oc;
    logic osc_d;
    logic [7:0] rdata;
    logic irq;
    logic wake;
    logic [2:0] halt_cnt;
    logic halt;
  } atc_top_t;

  typedef struct packed {
    logic [9:0] cnt;
  } atc_pre_t;

  typedef struct packed {
    logic meta;
    logic stable;
  } atc_sync_t;

endpackage : atc_pkg

// ==== atc_sync2.sv ====
// Two-flop synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ps

module atc_sync2 (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic async_i,
  output logic sync_o
);

  atc_pkg::atc_sync_t r;
  atc_pkg::atc_sync_t n;

  always_comb begin
    n = r;
    n.meta = async_i;
    n.stable = r.meta;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sync_o = r.stable;

endmodule : atc_sync2

// ==== atc_prescale.sv ====
// Prescaler: divides the timer source tick by the selected ratio.
`timescale 1ns/1ps

module atc_prescale (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic src_tick_i,
  input wire logic [2:0] sel_i,
  output logic tick_o
);

  atc_pkg::atc_pre_t r;
  atc_pkg::atc_pre_t n;
  logic [9:0] mask;

  always_comb begin
    n = r;
    mask = 10'h000;
    if (src_tick_i) begin
      n.cnt = r.cnt + 10'h001;
    end
    case (sel_i)
      3'h2: mask = `ATC_PRE_MASK_8;
      3'h3: mask = `ATC_PRE_MASK_32;
      3'h4: mask = `ATC_PRE_MASK_64;
      3'h5: mask = `ATC_PRE_MASK_128;
      3'h6: mask = `ATC_PRE_MASK_256;
      3'h7: mask = `ATC_PRE_MASK_1024;
      default: mask = 10'h000;
    endcase
  end

  // Select zero stops the counter; select one passes every source tick.
  assign tick_o = src_tick_i && (sel_i != 3'h0) && ((r.cnt & mask) == mask);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule : atc_prescale

// ==== atc_timer_chk.sv ====
// Port-level assertions for the timer, bound to its top module.
`timescale 1ns/1ps

module atc_timer_chk (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic osc_input_pin_i,
  input wire logic global_irq_en_i,
  input wire logic sleep_power_save_i,
  input wire logic irq_o,
  input wire logic pwm_output_pin_o,
  input wire logic osc_pins_claimed_o,
  input wire logic wake_o,
  input wire logic cpu_halt_o
);
  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  chk_rdata_idle:
    assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside an answer");
  chk_status_rsvd:
    assert property ($past(rd_i) && $past(addr_i) == 8'h22
                     |-> rdata_o[7:4] == 4'h0)
    else $error("status upper bits not zero");
  chk_sync_nobusy:
    assert property ($past(rd_i) && $past(addr_i) == 8'h22
                     && !$past(osc_pins_claimed_o)
                     && !$past(osc_pins_claimed_o, 2)
                     |-> rdata_o[2:0] == 3'h0)
    else $error("busy bit set in synchronous mode");
  chk_claim_write:
    assert property (wr_i && addr_i == 8'h22 && wdata_i[3]
                     |=> osc_pins_claimed_o)
    else $error("oscillator pins not claimed after select");
  chk_irq_gate:
    assert property (!global_irq_en_i ##1 !global_irq_en_i |-> !irq_o)
    else $error("interrupt with global enable off");
  chk_wake_sleep:
    assert property (wake_o |-> $past(sleep_power_save_i))
    else $error("wake outside power save");
  chk_halt_wake:
    assert property ($rose(wake_o) |-> $rose(cpu_halt_o))
    else $error("halt did not start with wake");
  chk_halt_len:
    assert property ($rose(cpu_halt_o) |-> cpu_halt_o[*4] ##1 !cpu_halt_o)
    else $error("halt not exactly four cycles");
endmodule : atc_timer_chk

bind atc_timer atc_timer_chk u_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .osc_input_pin_i(osc_input_pin_i), .global_irq_en_i(global_irq_en_i),
  .sleep_power_save_i(sleep_power_save_i), .irq_o(irq_o),
  .pwm_output_pin_o(pwm_output_pin_o),
  .osc_pins_claimed_o(osc_pins_claimed_o), .wake_o(wake_o),
  .cpu_halt_o(cpu_halt_o)
);

// ==== test_async_timer_counter_8bit.sv ====
// Self-checking testbench for the eight-bit asynchronous timer.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  mismatches++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end

module test_async_timer_counter_8bit;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic osc_input_pin_i = 1'b0;
  logic global_irq_en_i = 1'b0;
  logic sleep_power_save_i = 1'b0;
  logic [7:0] rdata_o;
  logic irq_o, pwm_output_pin_o, osc_pins_claimed_o, wake_o, cpu_halt_o;
  logic osc_run = 1'b0;
  logic [2:0] osc_div = 3'h0;
  logic [7:0] d, c1;
  int mismatches = 0;
  int comparisons = 0;
  time t1;

  atc_timer dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .osc_input_pin_i(osc_input_pin_i), .global_irq_en_i(global_irq_en_i),
    .sleep_power_save_i(sleep_power_save_i), .irq_o(irq_o),
    .pwm_output_pin_o(pwm_output_pin_o),
    .osc_pins_claimed_o(osc_pins_claimed_o), .wake_o(wake_o),
    .cpu_halt_o(cpu_halt_o));

  // ---------------------------------------------------------------------
  // Clocks and bus tasks
  // ---------------------------------------------------------------------
  always #2 clk_i = ~clk_i;

  // Oscillator half period of 8 clocks keeps it well below clk_i/2.
  always @(posedge clk_i) begin
    osc_div <= osc_div + 3'h1;
    if (osc_run && osc_div == 3'h7) osc_input_pin_i <= ~osc_input_pin_i;
  end

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd

  task wait_hi(input int sel, input int n);
    #1;
    for (int i = 0; i < n && (sel ? wake_o : irq_o) !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
  endtask : wait_hi

  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task t_reset;
    rd(8'h22, d); `CHK(d, 8'h00);
    rd(8'h25, d); `CHK(d, 8'h00);
    rd(8'h30, d); `CHK(d, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task t_count;
    wr(8'h24, 8'h10);
    rd(8'h24, d); `CHK(d, 8'h10);
    wr(8'h25, 8'h01);
    rd(8'h24, c1);
    rd(8'h24, d); `CHK(d - c1, 8'h02);
    wr(8'h25, 8'h00);
    $display("test count done");
  endtask : t_count

  task t_ovf_irq;
    wr(8'h39, 8'h01);
    wr(8'h38, 8'h03);
    wr(8'h24, 8'hfe);
    global_irq_en_i <= 1'b1;
    wr(8'h25, 8'h01);
    wait_hi(0, 20); `CHK(irq_o, 1'b1);
    rd(8'h38, d); `CHK(d[0], 1'b1);
    wr(8'h25, 8'h00);
    global_irq_en_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 `CHK(irq_o, 1'b0);
    wr(8'h38, 8'h03);
    global_irq_en_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 `CHK(irq_o, 1'b0);
    $display("test overflow irq done");
  endtask : t_ovf_irq

  task t_pwm;
    wr(8'h23, 8'hff);
    wr(8'h24, 8'h00);
    wr(8'h25, 8'h61);
    wait_hi(0, 600);
    t1 = $time;
    wr(8'h38, 8'h03);
    repeat (2) @(posedge clk_i);
    wait_hi(0, 600); `CHK(($time - t1) / 4, 510);
    `CHK(pwm_output_pin_o, 1'b1);
    wr(8'h25, 8'h71);
    repeat (520) @(posedge clk_i);
    #1 `CHK(pwm_output_pin_o, 1'b0);
    wr(8'h25, 8'h00);
    $display("test pwm done");
  endtask : t_pwm

  // Normal mode compare: toggle output, clear on match, then a /8 tick.
  task t_cmp;
    wr(8'h38, 8'h03);
    wr(8'h39, 8'h02);
    wr(8'h23, 8'h05);
    wr(8'h24, 8'h00);
    wr(8'h25, 8'h19);
    wait_hi(0, 20); `CHK(irq_o, 1'b1);
    `CHK(pwm_output_pin_o, 1'b1);
    rd(8'h38, d); `CHK(d[1], 1'b1);
    rd(8'h24, d); `CHK((d <= 8'h05), 1'b1);
    wr(8'h25, 8'h02);
    rd(8'h24, c1);
    repeat (14) @(posedge clk_i);
    rd(8'h24, d); `CHK(d - c1, 8'h02);
    wr(8'h25, 8'h00);
    wr(8'h39, 8'h01);
    wr(8'h38, 8'h03);
    $display("test compare done");
  endtask : t_cmp

  task t_async;
    @(posedge clk_i);
    global_irq_en_i <= 1'b0;
    wr(8'h22, 8'h08);
    #1 `CHK(osc_pins_claimed_o, 1'b1);
    // Count, compare and control are rewritten after the select change.
    wr(8'h24, 8'hfe);
    rd(8'h22, d); `CHK(d, 8'h0c);
    wr(8'h23, 8'h80);
    rd(8'h22, d); `CHK(d, 8'h0e);
    wr(8'h25, 8'h01);
    rd(8'h22, d); `CHK(d, 8'h0f);
    rd(8'h23, d); `CHK(d, 8'h80);
    wr(8'h38, 8'h03);
    sleep_power_save_i <= 1'b1;
    osc_run <= 1'b1;
    repeat (40) @(posedge clk_i);
    // Each register was written once only, so none was hit while busy.
    rd(8'h22, d); `CHK(d, 8'h08);
    wait_hi(1, 300); `CHK(wake_o, 1'b1);
    `CHK(irq_o, 1'b0);
    `CHK(cpu_halt_o, 1'b1);
    repeat (4) @(posedge clk_i);
    #1 `CHK(cpu_halt_o, 1'b0);
    @(posedge clk_i);
    sleep_power_save_i <= 1'b0;
    osc_run <= 1'b0;
    wr(8'h22, 8'h00);
    $display("test async done");
  endtask : t_async

  initial begin
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset;
    t_count;
    t_ovf_irq;
    t_pwm;
    t_cmp;
    t_async;
    test_done;
  end

  // The scenarios need about 1250 cycles; this margin catches a hang.
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    test_done;
  end
endmodule : test_async_timer_counter_8bit
